// >>> pkg/spp_defs.vh
// Purpose: Constants for the stream packet pacer.
// Assumes: 200 MHz system clock, 8 ns stream tick, 32-bit AXI4-Lite register bus.
// Notes: Byte offsets, field positions, reset values and timing figures.
`ifndef SPP_DEFS_VH
`define SPP_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define SPP_A_CTRL 8'h00
`define SPP_A_CHSEL 8'h04
`define SPP_A_PKTLEN 8'h08
`define SPP_A_IPD 8'h0C
`define SPP_A_FTD 8'h10
`define SPP_A_PAYLOAD 8'h14
`define SPP_A_BW 8'h18
`define SPP_A_TICKFREQ 8'h1C
`define SPP_A_HBTO 8'h20
`define SPP_A_IRQST 8'h24
`define SPP_A_IRQMSK 8'h28
`define SPP_A_STATUS 8'h2C

// ****************************************
// Fields and reset values
// ****************************************
`define SPP_CTRL_EN 0
`define SPP_CTRL_CHUNK 1
`define SPP_IRQ_DONE 0
`define SPP_IRQ_HB 1
`define SPP_PKTLEN_RST 16'h05DC
`define SPP_PKT_MIN 16'h0025
`define SPP_HDR_BYTES 16'h0024
`define SPP_LDR_BYTES 16'h0024
`define SPP_TRL_BYTES 16'h0024
`define SPP_HBTO_RST 32'h00000BB8
`define SPP_RESP_OK 2'h0
`define SPP_RESP_ERR 2'h2

// ****************************************
// Timing
// ****************************************
`define SPP_CLK_NS 5'h05
`define SPP_TICK_NS 4'h8
`define SPP_MS_NS 32'h000F4240
`define SPP_TICK_FREQ 32'h07735940

`endif

// >>> rtl/spp_pacer.v
// Purpose: Frames each acquired image into leader, payload and trailer packets and paces them.
// Assumes: Inputs synchronous to clk_sys; the stream sink takes one byte per tx_byte pulse.
// Notes: Tick strobe is a 5/8 phase accumulator, so ticks average exactly 8 ns.
`include "spp_defs.vh"
`default_nettype none

// Notes on behaviour
// [R1] Each frame goes out as one leader, one or more payloads, one trailer.
// [R2] Packet length shapes payload packets only; the last payload may be shorter.
// [R3] Payload packet data bytes equal packet length minus 36 header bytes.
// [R4] A programmable gap in 8 ns ticks separates consecutive packets.
// [R5] A readable register gives the tick frequency in ticks per second.
// [R6] Frame start waits a programmable tick count; zero adds nothing.
// [R7] Read-only payload size is image plus enabled chunk bytes, no headers.
// [R8] Channel selector steers length and gap writes; only channel 0 exists.
// [R9] Read-only assigned bandwidth derives from packet length and gap.
// [R10] One packet byte is sent per tick.
// [R11] Missing heartbeat within the timeout releases the connection for reconnection.
// [R12] Host waits up to its read timeout for a register read answer.
// [R13] Host waits up to its write timeout for a write acknowledge.
// [R14] Host packet timeout should exceed the programmed inter-packet gap.
// [R15] Gap starts after a packet's last byte and blocks the next packet.
module spp_pacer #(
    parameter CYC_PER_MS = `SPP_MS_NS / `SPP_CLK_NS
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire frame_ready,
    input wire [31:0] image_bytes,
    input wire [31:0] chunk_bytes,
    input wire hb_refresh,
    input wire conn_accept,
    output reg frame_taken,
    output reg pkt_start,
    output reg [1:0] pkt_kind,
    output reg [15:0] pkt_len,
    output reg tx_byte,
    output reg conn_open,
    output reg irq
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_HOLD = 4'h2;
    localparam [3:0] ST_SEND = 4'h4;
    localparam [3:0] ST_GAP = 4'h8;
    localparam [1:0] K_LDR = 2'h1;
    localparam [1:0] K_PAY = 2'h2;
    localparam [1:0] K_TRL = 2'h3;

    // ****************************************
    // Registers and state
    // ****************************************
    reg [1:0] ctrl_q;
    reg [7:0] chsel_q;
    reg [15:0] pktlen_q;
    reg [31:0] ipd_q, ftd_q, hbto_q, payload_q, bw_q;
    reg [1:0] irq_st_q, irq_msk_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg aw_full_q, w_full_q;
    reg [3:0] state_q;
    reg [3:0] acc_q;
    reg tick_q;
    reg [31:0] rem_q, wait_q;
    reg [15:0] cnt_q;
    reg ldr_sent_q, pl_sent_q;
    reg done_ev_q, hb_ev_q;
    reg [31:0] ms_cyc_q, ms_cnt_q;
    reg [47:0] num_q, quo_q;
    reg [48:0] rdiv_q;
    reg [32:0] den_q;
    reg [5:0] step_q;
    reg [31:0] rd_d;
    reg rd_ok_d;

    wire [15:0] data_per = pktlen_q - `SPP_HDR_BYTES;
    wire [31:0] take = (rem_q < {16'h0000, data_per}) ? rem_q : {16'h0000, data_per};
    wire wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
    wire wr_ch0 = (chsel_q == 8'h00);
    wire [31:0] be = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire [4:0] acc_sum = {1'b0, acc_q} + `SPP_CLK_NS;
    wire [48:0] rdiv_sh = {rdiv_q[47:0], num_q[47]};

    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [31:0] mask;
        begin
            merge = (old_v & ~mask) | (new_v & mask);
        end
    endfunction

    // Issue the next packet of the block
    task launch;
        begin
            pkt_start <= 1'b1;
            state_q <= ST_SEND;
            ldr_sent_q <= 1'b1;
            if (!ldr_sent_q) begin
                // [R1] leader opens block
                pkt_kind <= K_LDR;
                pkt_len <= `SPP_LDR_BYTES;
                cnt_q <= `SPP_LDR_BYTES;
            end else if (rem_q != 32'h00000000 || !pl_sent_q) begin
                // [R2] [R3] payload sized by length
                pkt_kind <= K_PAY;
                pkt_len <= take[15:0] + `SPP_HDR_BYTES;
                cnt_q <= take[15:0] + `SPP_HDR_BYTES;
                rem_q <= rem_q - take;
                pl_sent_q <= 1'b1;
            end else begin
                // [R1] trailer closes block
                pkt_kind <= K_TRL;
                pkt_len <= `SPP_TRL_BYTES;
                cnt_q <= `SPP_TRL_BYTES;
            end
        end
    endtask

    // ****************************************
    // Tick strobe and packet pacing
    // ****************************************
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            acc_q <= 4'h0;
            tick_q <= 1'b0;
            state_q <= ST_IDLE;
            rem_q <= 32'h00000000;
            wait_q <= 32'h00000000;
            cnt_q <= 16'h0000;
            ldr_sent_q <= 1'b0;
            pl_sent_q <= 1'b0;
            pkt_start <= 1'b0;
            pkt_kind <= 2'h0;
            pkt_len <= 16'h0000;
            tx_byte <= 1'b0;
            frame_taken <= 1'b0;
            done_ev_q <= 1'b0;
            payload_q <= 32'h00000000;
        end else begin
            // Keeps an 8 ns average on a 5 ns clock
            if (acc_sum >= `SPP_TICK_NS) begin
                acc_q <= acc_sum[3:0] - `SPP_TICK_NS;
                tick_q <= 1'b1;
            end else begin
                acc_q <= acc_sum[3:0];
                tick_q <= 1'b0;
            end
            // [R7] image plus chunk bytes
            payload_q <= image_bytes + (ctrl_q[`SPP_CTRL_CHUNK] ? chunk_bytes : 32'h00000000);
            pkt_start <= 1'b0;
            tx_byte <= 1'b0;
            frame_taken <= 1'b0;
            done_ev_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (frame_ready && ctrl_q[`SPP_CTRL_EN] && conn_open) begin
                        frame_taken <= 1'b1;
                        rem_q <= payload_q;
                        ldr_sent_q <= 1'b0;
                        pl_sent_q <= 1'b0;
                        wait_q <= ftd_q;
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    // [R6] frame start holdoff
                    if (wait_q == 32'h00000000) begin
                        launch;
                    end else if (tick_q) begin
                        wait_q <= wait_q - 32'h00000001;
                    end
                end
                ST_SEND: begin
                    // [R10] byte per tick
                    if (tick_q) begin
                        tx_byte <= 1'b1;
                        cnt_q <= cnt_q - 16'h0001;
                        if (cnt_q == 16'h0001) begin
                            if (pkt_kind == K_TRL) begin
                                done_ev_q <= 1'b1;
                            end
                            // [R15] gap follows last byte
                            wait_q <= ipd_q;
                            state_q <= ST_GAP;
                        end
                    end
                end
                ST_GAP: begin
                    // [R4] [R15] gap blocks next
                    if (wait_q == 32'h00000000) begin
                        if (pkt_kind == K_TRL) begin
                            state_q <= ST_IDLE;
                        end else begin
                            launch;
                        end
                    end else if (tick_q) begin
                        wait_q <= wait_q - 32'h00000001;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Heartbeat supervision
    // ****************************************
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ms_cyc_q <= 32'h00000000;
            ms_cnt_q <= 32'h00000000;
            conn_open <= 1'b0;
            hb_ev_q <= 1'b0;
        end else begin
            hb_ev_q <= 1'b0;
            if (!conn_open) begin
                ms_cyc_q <= 32'h00000000;
                ms_cnt_q <= 32'h00000000;
                conn_open <= conn_accept;
            end else if (hb_refresh) begin
                ms_cyc_q <= 32'h00000000;
                ms_cnt_q <= 32'h00000000;
            end else if (ms_cnt_q >= hbto_q) begin
                // [R11] release on timeout
                conn_open <= 1'b0;
                hb_ev_q <= 1'b1;
            end else if (ms_cyc_q == CYC_PER_MS - 1) begin
                ms_cyc_q <= 32'h00000000;
                ms_cnt_q <= ms_cnt_q + 32'h00000001;
            end else begin
                ms_cyc_q <= ms_cyc_q + 32'h00000001;
            end
        end
    end

    // ****************************************
    // Bandwidth divider
    // ****************************************
    // Serial divide keeps area small; result lags a setting change by up to ~100 cycles
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            num_q <= 48'h000000000000;
            quo_q <= 48'h000000000000;
            rdiv_q <= 49'h0000000000000;
            den_q <= 33'h000000000;
            step_q <= 6'h00;
            bw_q <= 32'h00000000;
        end else if (step_q == 6'h00) begin
            // [R9] length times rate over length plus gap
            num_q <= {16'h0000, pktlen_q} * {16'h0000, `SPP_TICK_FREQ};
            den_q <= {17'h00000, pktlen_q} + {1'b0, ipd_q};
            rdiv_q <= 49'h0000000000000;
            quo_q <= 48'h000000000000;
            step_q <= 6'h30;
        end else begin
            num_q <= {num_q[46:0], 1'b0};
            if (rdiv_sh >= {16'h0000, den_q}) begin
                rdiv_q <= rdiv_sh - {16'h0000, den_q};
                quo_q <= {quo_q[46:0], 1'b1};
            end else begin
                rdiv_q <= rdiv_sh;
                quo_q <= {quo_q[46:0], 1'b0};
            end
            if (step_q == 6'h01) begin
                bw_q <= (rdiv_sh >= {16'h0000, den_q}) ? {quo_q[30:0], 1'b1} : {quo_q[30:0], 1'b0};
            end
            step_q <= step_q - 6'h01;
        end
    end

    // ****************************************
    // Register read decode
    // ****************************************
    always @* begin
        rd_d = 32'h00000000;
        rd_ok_d = 1'b1;
        case (s_axi_araddr)
            `SPP_A_CTRL: rd_d = {30'h00000000, ctrl_q};
            `SPP_A_CHSEL: rd_d = {24'h000000, chsel_q};
            `SPP_A_PKTLEN: rd_d = {16'h0000, pktlen_q};
            `SPP_A_IPD: rd_d = ipd_q;
            `SPP_A_FTD: rd_d = ftd_q;
            `SPP_A_PAYLOAD: rd_d = payload_q;
            `SPP_A_BW: rd_d = bw_q;
            // [R5] tick frequency readback
            `SPP_A_TICKFREQ: rd_d = `SPP_TICK_FREQ;
            `SPP_A_HBTO: rd_d = hbto_q;
            `SPP_A_IRQST: rd_d = {30'h00000000, irq_st_q};
            `SPP_A_IRQMSK: rd_d = {30'h00000000, irq_msk_q};
            `SPP_A_STATUS: rd_d = {30'h00000000, conn_open, ~state_q[0]};
            default: rd_ok_d = 1'b0;
        endcase
    end

    // ****************************************
    // AXI4-Lite slave and register writes
    // ****************************************
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SPP_RESP_OK;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `SPP_RESP_OK;
            s_axi_rdata <= 32'h00000000;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            ctrl_q <= 2'h0;
            chsel_q <= 8'h00;
            pktlen_q <= `SPP_PKTLEN_RST;
            ipd_q <= 32'h00000000;
            ftd_q <= 32'h00000000;
            hbto_q <= `SPP_HBTO_RST;
            irq_st_q <= 2'h0;
            irq_msk_q <= 2'h0;
            irq <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
                aw_full_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_full_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            // Event set wins over a same-cycle clear
            irq_st_q <= irq_st_q | {hb_ev_q, done_ev_q};
            irq <= |(irq_st_q & irq_msk_q);
            if (wr_go) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `SPP_RESP_OK;
                case (awaddr_q)
                    `SPP_A_CTRL: ctrl_q <= (ctrl_q & ~be[1:0]) | (wdata_q[1:0] & be[1:0]);
                    `SPP_A_CHSEL: chsel_q <= (chsel_q & ~be[7:0]) | (wdata_q[7:0] & be[7:0]);
                    `SPP_A_PKTLEN: begin
                        // [R8] only channel 0 applies
                        if (wr_ch0 && wstrb_q[1:0] == 2'h3) begin
                            pktlen_q <= (wdata_q[15:0] < `SPP_PKT_MIN) ? `SPP_PKT_MIN
                                : wdata_q[15:0];
                        end
                    end
                    `SPP_A_IPD: begin
                        // [R8] gap on channel 0
                        if (wr_ch0) begin
                            ipd_q <= merge(ipd_q, wdata_q, be);
                        end
                    end
                    `SPP_A_FTD: ftd_q <= merge(ftd_q, wdata_q, be);
                    `SPP_A_HBTO: hbto_q <= merge(hbto_q, wdata_q, be);
                    `SPP_A_IRQST: begin
                        irq_st_q <= (irq_st_q & ~(wdata_q[1:0] & be[1:0]))
                            | {hb_ev_q, done_ev_q};
                    end
                    `SPP_A_IRQMSK: irq_msk_q <= (irq_msk_q & ~be[1:0]) | (wdata_q[1:0] & be[1:0]);
                    `SPP_A_PAYLOAD, `SPP_A_BW, `SPP_A_TICKFREQ, `SPP_A_STATUS: begin
                        s_axi_bresp <= `SPP_RESP_OK;
                    end
                    default: s_axi_bresp <= `SPP_RESP_ERR;
                endcase
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_d;
                s_axi_rresp <= rd_ok_d ? `SPP_RESP_OK : `SPP_RESP_ERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// >>> verification/spp_pacer_asserts.sv
// Purpose: Port-level checks for the stream packet pacer.
// Assumes: One clk_sys domain, sys_rst active high.
// Notes: Bound to every spp_pacer instance.
`default_nettype none
module spp_pacer_chk (
    input wire clk_sys,
    input wire sys_rst,
    input wire s_axi_awready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire pkt_start,
    input wire [1:0] pkt_kind,
    input wire [15:0] pkt_len,
    input wire tx_byte
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_leader_len: assert property (pkt_start && pkt_kind == 2'h1 |-> pkt_len == 16'h0024)
        else $error("leader length wrong");
    a_trailer_len: assert property (pkt_start && pkt_kind == 2'h3 |-> pkt_len == 16'h0024)
        else $error("trailer length wrong");
    a_payload_data: assert property (pkt_start && pkt_kind == 2'h2 |-> pkt_len > 16'h0024)
        else $error("payload without data");
    a_trailer_order: assert property (pkt_start && pkt_kind == 2'h3 |-> $past(pkt_kind) == 2'h2)
        else $error("trailer not after payload");
    a_payload_order: assert property (pkt_start && pkt_kind == 2'h2 |->
        $past(pkt_kind) inside {2'h1, 2'h2})
        else $error("payload out of order");
    // Ticks average 1.6 cycles, so three bytes in a row is too fast
    a_byte_rate: assert property (tx_byte [*2] |=> !tx_byte)
        else $error("bytes faster than tick");
    a_read_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken while busy");
endmodule
bind spp_pacer spp_pacer_chk u_chk (.clk_sys, .sys_rst, .s_axi_awready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .pkt_start, .pkt_kind, .pkt_len, .tx_byte);
`default_nettype wire

// >>> verification/spp_host_model.sv
// Purpose: Host receiver and driver stand-in for the stream packet pacer.
// Assumes: Packet and byte strobes are registered pulses on clk_sys.
// Notes: Counters are read by the bench through the hierarchy.
`default_nettype none
module spp_host_model #(
    parameter int HB_GAP = 10,
    parameter int PKT_TO = 400
) (
    input wire logic clk_sys,
    input wire logic pkt_start,
    input wire logic [1:0] pkt_kind,
    input wire logic [15:0] pkt_len,
    input wire logic tx_byte,
    input wire logic conn_open,
    input wire logic hb_en,
    input wire logic acc_en,
    output logic hb_refresh = 1'b0,
    output logic conn_accept = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0, cur_len = 0, n_pkt = 0, n_data = 0, byte_err = 0;
    int idle = 0, gap = 0, late = 0, hb_cnt = 0, last_plen = 0;
    logic [9:0] kinds = 10'h000;
    always @(posedge clk_sys) begin
        hb_cnt <= (hb_cnt == HB_GAP - 1) ? 0 : hb_cnt + 1;
        hb_refresh <= hb_en && hb_cnt == HB_GAP - 1;
        conn_accept <= acc_en && !conn_open;
        idle <= tx_byte ? 0 : idle + 1;
        if (tx_byte && !pkt_start) cnt <= cnt + 1;
        if (pkt_start) begin
            if (n_pkt > 0 && cnt != cur_len) byte_err <= byte_err + 1;
            cnt <= tx_byte ? 1 : 0;
            cur_len <= pkt_len;
            n_pkt <= n_pkt + 1;
            gap <= idle;
            kinds <= {kinds[7:0], pkt_kind};
            if (pkt_kind == 2'h2) n_data <= n_data + pkt_len - 36;
            if (pkt_kind == 2'h2) last_plen <= pkt_len;
        end
        if (idle == PKT_TO && pkt_kind inside {2'h1, 2'h2}) late <= late + 1;
    end
endmodule
`default_nettype wire

// >>> verification/spp_tb.sv
// Purpose: Self-checking bench for the stream packet pacer.
// Assumes: 200 MHz clk_sys, heartbeat millisecond cut to 20 cycles.
// Notes: Gap and holdoff are judged by differences, so tick phase cancels.
`include "spp_defs.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0, sys_rst = 1'b1, hb_en = 1'b1, acc_en = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, image_bytes = 32'h96, chunk_bytes = 32'hA;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, frame_ready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, pkt_kind;
    logic [31:0] s_axi_rdata;
    logic [15:0] pkt_len;
    logic hb_refresh, conn_accept, frame_taken, pkt_start, tx_byte, conn_open, irq;
    int checks = 0, miscompares = 0;
    spp_pacer #(.CYC_PER_MS(20)) DUT (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frame_ready, .image_bytes,
        .chunk_bytes, .hb_refresh, .conn_accept, .frame_taken, .pkt_start, .pkt_kind, .pkt_len,
        .tx_byte, .conn_open, .irq);
    spp_host_model host (.clk_sys, .pkt_start, .pkt_kind, .pkt_len, .tx_byte, .conn_open,
        .hb_en, .acc_en, .hb_refresh, .conn_accept);
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ********
    // Helpers
    // ********
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic final_report;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic bound(input int t);
        if (t >= 2000) begin
            miscompares++;
            final_report();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        t = 0;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            t++;
        end while (s_axi_bvalid !== 1'b1 && t < 2000);
        bound(t);
        s_axi_bready <= 1'b0;
        chk("bresp", s_axi_bresp, 2'h0);
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er = 2'h0);
        int t;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        t = 0;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            t++;
        end while (s_axi_rvalid !== 1'b1 && t < 2000);
        bound(t);
        s_axi_rready <= 1'b0;
        chk(n, s_axi_rdata, e);
        chk("rresp", s_axi_rresp, er);
    endtask
    task automatic frame(input int ipd, input int ftd, output int gap, output int lat);
        int n0, d0, t;
        wr(`SPP_A_IPD, ipd);
        wr(`SPP_A_FTD, ftd);
        n0 = host.n_pkt;
        d0 = host.n_data;
        frame_ready <= 1'b1;
        t = 0;
        do begin
            @(posedge clk_sys);
            t++;
        end while (frame_taken !== 1'b1 && t < 2000);
        bound(t);
        frame_ready <= 1'b0;
        lat = 0;
        while (pkt_start !== 1'b1 && lat < 2000) begin
            @(posedge clk_sys);
            lat++;
        end
        bound(lat);
        t = 0;
        while (!(host.n_pkt == n0 + 5 && host.cnt == 36) && t < 2000) begin
            @(posedge clk_sys);
            t++;
        end
        bound(t);
        repeat (100) @(posedge clk_sys);
        chk("kinds", host.kinds, 10'h1AB);
        chk("packets", host.n_pkt - n0, 5);
        chk("last len", host.last_plen, 32'h44);
        chk("data", host.n_data - d0, 32'hA0);
        gap = host.gap;
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_regs;
        rd("pktlen", `SPP_A_PKTLEN, 32'h5DC);
        rd("hbto", `SPP_A_HBTO, 32'hBB8);
        wr(`SPP_A_TICKFREQ, 32'h0);
        rd("tickfreq", `SPP_A_TICKFREQ, 32'h07735940);
        rd("unmapped", 8'h30, 32'h0, 2'h2);
        wr(`SPP_A_CHSEL, 32'h1);
        rd("chsel", `SPP_A_CHSEL, 32'h1);
        wr(`SPP_A_PKTLEN, 32'h64);
        rd("pktlen ch1", `SPP_A_PKTLEN, 32'h5DC);
        wr(`SPP_A_CHSEL, 32'h0);
    endtask
    task automatic t_frames;
        int g0, g1, l0, l1;
        wr(`SPP_A_PKTLEN, 32'h64);
        wr(`SPP_A_IRQMSK, 32'h0);
        rd("payload", `SPP_A_PAYLOAD, 32'h96);
        wr(`SPP_A_CTRL, 32'h3);
        rd("payload chunk", `SPP_A_PAYLOAD, 32'hA0);
        frame(0, 0, g0, l0);
        frame(20, 25, g1, l1);
        chk("gap", (g1 - g0) inside {[30:34]}, 1'b1);
        chk("holdoff", (l1 - l0) inside {[38:42]}, 1'b1);
        chk("no holdoff", l0 <= 2, 1'b1);
        chk("bytes", host.byte_err, 0);
        chk("late", host.late, 0);
    endtask
    task automatic t_irq;
        chk("irq masked", irq, 1'b0);
        rd("done", `SPP_A_IRQST, 32'h1);
        wr(`SPP_A_IRQMSK, 32'h1);
        repeat (3) @(posedge clk_sys);
        chk("irq on", irq, 1'b1);
        wr(`SPP_A_IRQST, 32'h1);
        repeat (3) @(posedge clk_sys);
        chk("irq off", irq, 1'b0);
        rd("cleared", `SPP_A_IRQST, 32'h0);
    endtask
    task automatic t_bw;
        wr(`SPP_A_IPD, 32'h0);
        repeat (110) @(posedge clk_sys);
        rd("bw full", `SPP_A_BW, 32'h07735940);
        wr(`SPP_A_IPD, 32'h64);
        repeat (110) @(posedge clk_sys);
        rd("bw half", `SPP_A_BW, 32'h03B9ACA0);
    endtask
    task automatic t_hb;
        int t;
        wr(`SPP_A_HBTO, 32'h3);
        wr(`SPP_A_IRQMSK, 32'h2);
        repeat (200) @(posedge clk_sys);
        chk("kept open", conn_open, 1'b1);
        hb_en <= 1'b0;
        acc_en <= 1'b0;
        t = 0;
        do begin
            @(posedge clk_sys);
            t++;
        end while (conn_open === 1'b1 && t < 2000);
        bound(t);
        chk("hb drop", t inside {[48:64]}, 1'b1);
        repeat (3) @(posedge clk_sys);
        chk("irq hb", irq, 1'b1);
        rd("hb status", `SPP_A_IRQST, 32'h2);
        acc_en <= 1'b1;
        hb_en <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk("reopen", conn_open, 1'b1);
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_regs();
        t_frames();
        t_irq();
        t_bw();
        t_hb();
        final_report();
    end
endmodule
`default_nettype wire
